// ===== shared/raic_pkg.sv
// shared constants and types for the reset and interrupt control block
package raic_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned IO_AW = 6;
  localparam int unsigned PC_W = 9;

  // i/o space addresses
  localparam logic [IO_AW-1:0] ADDR_CORE_CTRL = 6'h35;
  localparam logic [IO_AW-1:0] ADDR_TMR_FLAG = 6'h38;
  localparam logic [IO_AW-1:0] ADDR_TMR_MASK = 6'h39;
  localparam logic [IO_AW-1:0] ADDR_GEN_MASK = 6'h3B;
  localparam logic [IO_AW-1:0] ADDR_STATUS = 6'h3F;

  // field positions
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned EXT_EN_BIT = 6;
  localparam int unsigned OVF_BIT = 1;
  localparam int unsigned SLEEP_EN_BIT = 5;
  localparam int unsigned SLEEP_MODE_BIT = 4;
  localparam int unsigned SENSE_HI_BIT = 1;
  localparam int unsigned SENSE_LO_BIT = 0;
  localparam logic [DATA_W-1:0] REG_INIT = 8'h00;

  // sense control codes for the external pin
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_RSVD = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // vector addresses, lowest is most urgent
  localparam logic [PC_W-1:0] VEC_RESET = 9'h000;
  localparam logic [PC_W-1:0] VEC_EXT = 9'h001;
  localparam logic [PC_W-1:0] VEC_OVF = 9'h002;
  localparam logic [PC_W-1:0] VEC_CMP = 9'h003;

  // timing
  localparam int unsigned PUSH_CYCLES = 4;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned RST_PIN_MIN_NS = 50;
  localparam int unsigned RST_PIN_RAW =
    (RST_PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_PIN_CYCLES =
    (RST_PIN_RAW < 1) ? 1 : RST_PIN_RAW;
  localparam int unsigned TOUT_WDT_CYCLES = 16384;
  localparam int unsigned POR_TIME_US = 3000;
  localparam int unsigned WDT_OSC_KHZ = 1024;
  localparam int unsigned POR_WDT_CYCLES =
    POR_TIME_US * WDT_OSC_KHZ / 1000;

  typedef struct packed {
    logic [IO_AW-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wrEn;
    logic rdEn;
  } raic_io_s;

  typedef struct packed {
    logic instrDone;
    logic retiExec;
  } raic_core_s;

  typedef struct packed {
    logic load;
    logic [PC_W-1:0] addr;
  } raic_vec_s;

  typedef enum logic [1:0] {SRC_NONE, SRC_EXT, SRC_OVF, SRC_CMP} raic_src_e;
  typedef enum logic {ST_RUN, ST_PUSH} raic_state_e;
endpackage

// ===== logic/raic_delay_timer.sv
// start-up delay counter stepped by watchdog oscillator ticks
`timescale 1ns/10ps
module raic_delay_timer #(
  parameter int unsigned CW = 15
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic restart,
  input wire logic tick,
  input wire logic [CW-1:0] limit,
  output logic done
);
  logic [CW-1:0] cnt_r;
  logic done_r;
  wire atLimit = (cnt_r >= limit);

  // restart holds the count at zero, so counting begins after it drops
  always_ff @(posedge core_clk) begin
    if (srst || restart) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      if (tick && !atLimit) begin
        cnt_r <= cnt_r + 1'b1;
      end
      done_r <= atLimit;
    end
  end

  assign done = done_r;
endmodule

// ===== logic/raic_top.sv
// reset merging, start-up delay and vectored interrupt control
// Operation
// - source taken only with own and global enable
// - vectors 0x000 reset to 0x003 comparator
// - lower vector address wins priority
// - reset on supply, pin low, watchdog expiry
// - registers initialised in reset, fetch from zero
// - supply start waits oscillator-timed start-up period
// - pin release waits 16K oscillator cycles
// - watchdog pulse one cycle, count after it
// - take clears global enable, return sets it
// - vectoring clears served source's flag
// - writing one clears flag, zero keeps
// - flags held while own enable clear
// - held flags served by priority when enabled
// - level external request has no flag
// - status register not saved nor restored
// - mask registers at 0x3B and 0x39
// - bit 6 enables pin; sense selects mode
// - pin condition detected even when output
// - reserved general mask bits read zero
// - sense 00 low, 10 fall, 11 rise
// - vector at least four cycles after flag
// - one main instruction after return first
`timescale 1ns/10ps
module raic_top
  import raic_pkg::*;
#(
  parameter int unsigned TOUT_TICKS = TOUT_WDT_CYCLES,
  parameter int unsigned POR_TICKS = POR_WDT_CYCLES,
  parameter int unsigned TIMER_W = $clog2(TOUT_TICKS + 1)
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic supplyOkN,
  input wire logic rstPinN,
  input wire logic wdtExpire,
  input wire logic wdtEnable,
  input wire logic wdtOscTick,
  input wire raic_io_s ioBus,
  output logic [DATA_W-1:0] ioRdData,
  input wire logic extPin,
  input wire logic ovfEvent,
  input wire logic cmpEvent,
  input wire logic cmpIrqEn,
  input wire raic_core_s coreStat,
  output logic coreRst,
  output logic pushPc,
  output raic_vec_s vecOut
);
  // ---------------- reset path ----------------
  logic [3:0] pinLowCnt_r;
  logic porKind_r;
  logic coreRst_r;
  logic delayDone;

  // pin must stay low the minimum width; at this clock one sample does
  wire pinRst = !rstPinN &&
    (pinLowCnt_r >= 4'(RST_PIN_CYCLES - 1));
  // watchdog request is a single-cycle pulse, gated by its enable
  wire wdtPulse = wdtExpire && wdtEnable;
  wire supplyRst = supplyOkN;
  wire rstSrc = supplyRst || pinRst || wdtPulse;
  wire [TIMER_W-1:0] delayLimit = porKind_r ?
    TIMER_W'(POR_TICKS) : TIMER_W'(TOUT_TICKS);
  wire coreRstNxt = rstSrc || !delayDone;
  wire inRst = srst || coreRst_r;

  raic_delay_timer #(
    .CW(TIMER_W)
  ) u_delay (
    .core_clk(core_clk),
    .srst(srst),
    .restart(rstSrc),
    .tick(wdtOscTick),
    .limit(delayLimit),
    .done(delayDone)
  );

  // low-time counter and which start-up period applies
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinLowCnt_r <= '0;
      porKind_r <= 1'b1;
      coreRst_r <= 1'b1;
    end else begin
      pinLowCnt_r <= rstPinN ? '0 :
        ((&pinLowCnt_r) ? pinLowCnt_r : pinLowCnt_r + 1'b1);
      if (supplyRst) begin
        porKind_r <= 1'b1;
      end else if (pinRst || wdtPulse) begin
        porKind_r <= 1'b0;
      end
      coreRst_r <= coreRstNxt;
    end
  end

  // ---------------- register decode ----------------
  logic extEn_r;
  logic ovfEn_r;
  logic [1:0] sense_r;
  logic [1:0] sleepBits_r;
  logic globalEn_r;
  logic ovfFlag_r;
  logic extFlag_r;
  logic cmpFlag_r;
  logic extPinPrev_r;
  logic retiBlock_r;
  raic_state_e state_r;
  raic_src_e srcSel_r;
  logic [1:0] pushCnt_r;
  logic pushPc_r;
  logic vecLoad_r;
  logic [PC_W-1:0] vecAddr_r;
  logic [DATA_W-1:0] ioRdData_r;

  // write strobes per register
  wire wrGen = ioBus.wrEn && (ioBus.addr == ADDR_GEN_MASK);
  wire wrTmask = ioBus.wrEn && (ioBus.addr == ADDR_TMR_MASK);
  wire wrTflag = ioBus.wrEn && (ioBus.addr == ADDR_TMR_FLAG);
  wire wrCtrl = ioBus.wrEn && (ioBus.addr == ADDR_CORE_CTRL);
  wire wrStatus = ioBus.wrEn && (ioBus.addr == ADDR_STATUS);

  // read images; unused and reserved bits are zero
  wire [DATA_W-1:0] genImg = DATA_W'({extEn_r, 6'h00});
  wire [DATA_W-1:0] tmaskImg = DATA_W'({ovfEn_r, 1'b0});
  wire [DATA_W-1:0] tflagImg = DATA_W'({ovfFlag_r, 1'b0});
  wire [DATA_W-1:0] ctrlImg = DATA_W'({sleepBits_r, 2'h0, sense_r});
  // only the enable bit lives here; arithmetic flags sit in the core
  wire [DATA_W-1:0] statImg = DATA_W'({globalEn_r, 7'h00});
  wire [DATA_W-1:0] rdValue =
    (ioBus.addr == ADDR_GEN_MASK) ? genImg :
    (ioBus.addr == ADDR_TMR_MASK) ? tmaskImg :
    (ioBus.addr == ADDR_TMR_FLAG) ? tflagImg :
    (ioBus.addr == ADDR_CORE_CTRL) ? ctrlImg :
    (ioBus.addr == ADDR_STATUS) ? statImg : REG_INIT;

  // ---------------- request logic ----------------
  // the pin is read as a level even when driven by its own port
  wire fallEdge = extPinPrev_r && !extPin;
  wire riseEdge = !extPinPrev_r && extPin;
  wire levelMode = (sense_r == SENSE_LOW);
  wire extEdge = ((sense_r == SENSE_FALL) && fallEdge) ||
    ((sense_r == SENSE_RISE) && riseEdge);
  // level mode requests straight from the pin, nothing remembered
  wire extReq = extEn_r &&
    (levelMode ? !extPin : extFlag_r);
  wire ovfReq = ovfEn_r && ovfFlag_r;
  wire cmpReq = cmpIrqEn && cmpFlag_r;
  wire raic_src_e winner = extReq ? SRC_EXT :
    ovfReq ? SRC_OVF : cmpReq ? SRC_CMP : SRC_NONE;
  // the return boundary itself is not a main instruction, so it never takes
  wire take = (state_r == ST_RUN) && globalEn_r && !retiBlock_r &&
    !coreStat.retiExec && coreStat.instrDone && (winner != SRC_NONE) &&
    !coreRst_r;
  wire pushLast = (state_r == ST_PUSH) &&
    (pushCnt_r == 2'(PUSH_CYCLES - 1));
  wire clrExtHw = pushLast && (srcSel_r == SRC_EXT);
  wire clrOvfHw = pushLast && (srcSel_r == SRC_OVF);
  wire clrCmpHw = pushLast && (srcSel_r == SRC_CMP);
  wire ovfSwClr = wrTflag && ioBus.wrData[OVF_BIT];
  wire [PC_W-1:0] vecSel = (srcSel_r == SRC_EXT) ? VEC_EXT :
    (srcSel_r == SRC_OVF) ? VEC_OVF : VEC_CMP;

  // flag next values: a new event always beats a clear
  wire extFlagNxt = extEdge ||
    (extFlag_r && !clrExtHw && !levelMode);
  wire ovfFlagNxt = ovfEvent ||
    (ovfFlag_r && !ovfSwClr && !clrOvfHw);
  wire cmpFlagNxt = cmpEvent || (cmpFlag_r && !clrCmpHw);
  // hardware clear on take outranks a software write; no state saved
  wire globalEnNxt = take ? 1'b0 :
    coreStat.retiExec ? 1'b1 :
    wrStatus ? ioBus.wrData[GLOBAL_EN_BIT] : globalEn_r;
  // the boundary after a return ends one main instruction
  wire retiBlockNxt = coreStat.retiExec ? 1'b1 :
    coreStat.instrDone ? 1'b0 : retiBlock_r;

  // ---------------- control registers ----------------
  always_ff @(posedge core_clk) begin
    if (inRst) begin
      extEn_r <= 1'b0;
      ovfEn_r <= 1'b0;
      sense_r <= SENSE_LOW;
      sleepBits_r <= 2'h0;
      globalEn_r <= 1'b0;
    end else begin
      if (wrGen) extEn_r <= ioBus.wrData[EXT_EN_BIT];
      if (wrTmask) ovfEn_r <= ioBus.wrData[OVF_BIT];
      if (wrCtrl) begin
        sense_r <= {ioBus.wrData[SENSE_HI_BIT],
          ioBus.wrData[SENSE_LO_BIT]};
        sleepBits_r <= {ioBus.wrData[SLEEP_EN_BIT],
          ioBus.wrData[SLEEP_MODE_BIT]};
      end
      globalEn_r <= globalEnNxt;
    end
  end

  // pending flags and pin history
  always_ff @(posedge core_clk) begin
    if (inRst) begin
      extFlag_r <= 1'b0;
      ovfFlag_r <= 1'b0;
      cmpFlag_r <= 1'b0;
      extPinPrev_r <= 1'b1;
      retiBlock_r <= 1'b0;
    end else begin
      extFlag_r <= extFlagNxt;
      ovfFlag_r <= ovfFlagNxt;
      cmpFlag_r <= cmpFlagNxt;
      extPinPrev_r <= extPin;
      retiBlock_r <= retiBlockNxt;
    end
  end

  // entry sequence: four push cycles, then a one-cycle vector load
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= ST_RUN;
      srcSel_r <= SRC_NONE;
      pushCnt_r <= '0;
      pushPc_r <= 1'b0;
    end else if (coreRst_r) begin
      state_r <= ST_RUN;
      pushPc_r <= 1'b0;
      pushCnt_r <= '0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (take) begin
            state_r <= ST_PUSH;
            srcSel_r <= winner;
            pushPc_r <= 1'b1;
            pushCnt_r <= '0;
          end
        end
        ST_PUSH: begin
          pushCnt_r <= pushCnt_r + 1'b1;
          if (pushLast) begin
            state_r <= ST_RUN;
            pushPc_r <= 1'b0;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // vector output; the reset vector is issued as reset lets go
  always_ff @(posedge core_clk) begin
    if (srst) begin
      vecLoad_r <= 1'b0;
      vecAddr_r <= VEC_RESET;
    end else begin
      vecLoad_r <= pushLast || (coreRst_r && !coreRstNxt);
      if (coreRst_r) begin
        vecAddr_r <= VEC_RESET;
      end else if (pushLast) begin
        vecAddr_r <= vecSel;
      end
    end
  end

  // registered read data, held between reads
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ioRdData_r <= REG_INIT;
    end else if (ioBus.rdEn) begin
      ioRdData_r <= rdValue;
    end
  end

  assign ioRdData = ioRdData_r;
  assign coreRst = coreRst_r;
  assign pushPc = pushPc_r;
  assign vecOut = '{load: vecLoad_r, addr: vecAddr_r};

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_take_enables: assert property (
    $rose(pushPc_r) |-> $past(globalEn_r) && ($past(extReq) ||
      $past(ovfReq) || $past(cmpReq)))
    else $error("interrupt taken without enables");

  chk_push_then_vec: assert property (
    $rose(pushPc_r) |-> pushPc_r [*4] ##1 (vecLoad_r && !pushPc_r))
    else $error("vector not after four push cycles");

  chk_ie_cleared: assert property (
    $rose(pushPc_r) |-> !globalEn_r)
    else $error("global enable kept on entry");

  chk_return_from_interrupt_sets_ie: assert property (
    (coreStat.retiExec && !inRst) |=> globalEn_r || coreRst_r)
    else $error("return did not set global enable");

  chk_ext_priority: assert property (
    (take && extReq) |=> (srcSel_r == SRC_EXT))
    else $error("external request lost priority");

  chk_vec_range: assert property (
    vecLoad_r |-> (vecAddr_r <= VEC_CMP))
    else $error("vector outside table");

  chk_hw_clear: assert property (
    (clrOvfHw && !ovfEvent && !inRst) |=> !ovfFlag_r)
    else $error("served flag not cleared");

  chk_w1c_flag: assert property (
    (ovfSwClr && !ovfEvent && !inRst) |=> !ovfFlag_r)
    else $error("write one did not clear flag");

  chk_set_wins: assert property (
    (ovfEvent && !inRst) |=> ovfFlag_r)
    else $error("overflow event lost");

  chk_level_noflag: assert property (
    (levelMode && !inRst) |=> !extFlag_r || !levelMode)
    else $error("level mode kept a flag");

  chk_return_from_interrupt_gap: assert property (
    (retiBlock_r || coreStat.retiExec) |=> !$rose(pushPc_r))
    else $error("interrupt before one main instruction");

  chk_rst_release: assert property (
    $fell(coreRst_r) |-> $past(delayDone) && !$past(rstSrc))
    else $error("core released before delay done");

  chk_gen_reserved: assert property (
    (ioBus.rdEn && ioBus.addr == ADDR_GEN_MASK) |=>
      (ioRdData_r[7] == 1'b0) && (ioRdData_r[5:0] == 6'h00))
    else $error("reserved mask bits not zero");
endmodule

// ===== sim/raic_core_model.sv
// core stand-in: instruction boundaries and interrupt returns
`timescale 1ns/10ps
module raic_core_model
  import raic_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic coreRst,
  input wire logic pushPc,
  input wire raic_vec_s vecOut,
  input wire logic slow,
  input wire logic retReq,
  output raic_core_s coreStat
);
  logic [1:0] phase_r;
  logic retPend_r;
  logic bound;
  // no boundary while pushing; slow mode mimics three-cycle instructions
  assign bound = !pushPc && !vecOut.load && (!slow || phase_r == 2'h2);
  // a requested return rides on the next instruction boundary
  always_ff @(posedge core_clk) begin
    if (srst || coreRst) begin
      phase_r <= 2'h0;
      retPend_r <= 1'b0;
      coreStat <= '0;
    end else begin
      phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
      coreStat.instrDone <= bound;
      coreStat.retiExec <= bound && (retPend_r || retReq);
      retPend_r <= (retPend_r || retReq) && !bound;
    end
  end
endmodule

// ===== sim/testbench.sv
// self-checking bench for the reset and interrupt control block
`timescale 1ns/10ps
module testbench
  import raic_pkg::*;
;
  localparam int unsigned TOUT = 8;
  localparam int unsigned POR = 5;
  logic core_clk = 1'b0, srst = 1'b1, supplyOkN = 1'b0, rstPinN = 1'b1;
  logic wdtExpire = 1'b0, wdtEnable = 1'b0, wdtOscTick = 1'b0;
  logic extPin = 1'b1, ovfEvent = 1'b0, cmpEvent = 1'b0, cmpIrqEn = 1'b0;
  logic slow = 1'b0, retReq = 1'b0, coreRst, pushPc;
  logic [1:0] tickPh_r = 2'h0;
  logic [1:0] senseTab [4] = '{SENSE_FALL, SENSE_RISE, SENSE_RSVD, SENSE_LOW};
  raic_io_s ioBus = '0;
  raic_core_s coreStat;
  raic_vec_s vecOut;
  logic [DATA_W-1:0] ioRdData;
  int mismatches = 0;
  int nChecks = 0;

  always #25 core_clk = ~core_clk;
  // oscillator tick every third clock, slower than the core on purpose
  always @(posedge core_clk) begin
    tickPh_r <= (tickPh_r == 2'h2) ? 2'h0 : tickPh_r + 2'h1;
    wdtOscTick <= (tickPh_r == 2'h2);
  end

  raic_top #(.TOUT_TICKS(TOUT), .POR_TICKS(POR)) raic_top_inst (
    .core_clk(core_clk), .srst(srst), .supplyOkN(supplyOkN),
    .rstPinN(rstPinN), .wdtExpire(wdtExpire), .wdtEnable(wdtEnable),
    .wdtOscTick(wdtOscTick), .ioBus(ioBus), .ioRdData(ioRdData),
    .extPin(extPin), .ovfEvent(ovfEvent), .cmpEvent(cmpEvent),
    .cmpIrqEn(cmpIrqEn), .coreStat(coreStat), .coreRst(coreRst),
    .pushPc(pushPc), .vecOut(vecOut));
  raic_core_model raic_core_model_inst (
    .core_clk(core_clk), .srst(srst), .coreRst(coreRst), .pushPc(pushPc),
    .vecOut(vecOut), .slow(slow), .retReq(retReq), .coreStat(coreStat));

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [8:0] seen, exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    mismatches++;
    $display("BAD %s exp done seen timeout", what);
    giveVerdict();
  endtask
  // one bus cycle: strobe for one edge, then idle
  task automatic io(input logic [IO_AW-1:0] a, input logic [7:0] d,
                    input logic wr);
    @(posedge core_clk);
    ioBus <= '{addr: a, wrData: d, wrEn: wr, rdEn: !wr};
    @(posedge core_clk);
    ioBus <= '0;
  endtask
  task automatic rd(input logic [IO_AW-1:0] a, input logic [7:0] exp);
    io(a, 8'h00, 1'b0);
    #1;
    chk("ioRdData", {1'b0, ioRdData}, {1'b0, exp});
  endtask
  // wait for a vector load, counting push cycles on the way
  task automatic vec(input logic [PC_W-1:0] exp);
    int n = 0;
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge core_clk);
      #1;
      if (pushPc === 1'b1) n++;
      if (vecOut.load === 1'b1) break;
    end
    if (i == 200) begin
      hang("vecOut.load");
    end else begin
      chk("vecOut.addr", vecOut.addr, exp);
      chk("pushPc cycles", 9'(n), 9'h004);
    end
  endtask
  task automatic noVec(input int c);
    int n = 0;
    repeat (c) begin
      @(posedge core_clk);
      #1;
      if (vecOut.load !== 1'b0) n++;
    end
    chk("loads", 9'(n), 9'h000);
  endtask
  task automatic doRet();
    @(posedge core_clk);
    retReq <= 1'b1;
    @(posedge core_clk);
    retReq <= 1'b0;
  endtask
  // count oscillator ticks until the core is let go
  task automatic rstSeq(input int lim);
    int n = 0;
    int i;
    for (i = 0; i < 300; i++) begin
      #1;
      if (coreRst === 1'b0 && i > 2) break;
      if (wdtOscTick === 1'b1 && coreRst === 1'b1) n++;
      @(posedge core_clk);
    end
    if (i == 300) begin
      hang("coreRst");
    end else begin
      chk("reset load", 9'(vecOut.load), 9'h001);
      chk("reset addr", vecOut.addr, VEC_RESET);
      chk("ticks", 9'(n >= lim - 1 && n <= lim + 2), 9'h001);
    end
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rstSeq(POR);
    rd(ADDR_GEN_MASK, REG_INIT);
    rd(ADDR_TMR_MASK, REG_INIT);
    rd(ADDR_STATUS, REG_INIT);
    io(ADDR_GEN_MASK, 8'hFF, 1'b1);
    rd(ADDR_GEN_MASK, 8'h40);
    io(ADDR_TMR_MASK, 8'hFF, 1'b1);
    rd(ADDR_TMR_MASK, 8'h02);
    rd(6'h20, 8'h00);
    // overflow held while global enable is off
    @(posedge core_clk);
    ovfEvent <= 1'b1;
    @(posedge core_clk);
    ovfEvent <= 1'b0;
    noVec(10);
    rd(ADDR_TMR_FLAG, 8'h02);
    io(ADDR_TMR_FLAG, 8'h00, 1'b1);
    rd(ADDR_TMR_FLAG, 8'h02);
    io(ADDR_TMR_FLAG, 8'h02, 1'b1);
    rd(ADDR_TMR_FLAG, 8'h00);
    // three sources pending at once, served one by one with a slow core
    io(ADDR_CORE_CTRL, {6'h00, SENSE_FALL}, 1'b1);
    @(posedge core_clk);
    slow <= 1'b1;
    ovfEvent <= 1'b1;
    cmpEvent <= 1'b1;
    extPin <= 1'b0;
    @(posedge core_clk);
    ovfEvent <= 1'b0;
    cmpEvent <= 1'b0;
    cmpIrqEn <= 1'b1;
    io(ADDR_STATUS, 8'h80, 1'b1);
    vec(VEC_EXT);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_TMR_FLAG, 8'h02);
    doRet();
    vec(VEC_OVF);
    rd(ADDR_TMR_FLAG, 8'h00);
    doRet();
    vec(VEC_CMP);
    doRet();
    noVec(20);
    rd(ADDR_STATUS, 8'h80);
    @(posedge core_clk);
    slow <= 1'b0;
    extPin <= 1'b1;
    io(ADDR_STATUS, 8'h00, 1'b1);
    // short low pulse under each sense code, enable taken afterwards
    for (int k = 0; k < 4; k++) begin
      io(ADDR_CORE_CTRL, {6'h00, senseTab[k]}, 1'b1);
      @(posedge core_clk);
      extPin <= 1'b0;
      repeat (3) @(posedge core_clk);
      extPin <= 1'b1;
      repeat (3) @(posedge core_clk);
      io(ADDR_STATUS, 8'h80, 1'b1);
      if (k < 2) begin
        vec(VEC_EXT);
        doRet();
      end
      noVec(20);
      io(ADDR_STATUS, 8'h00, 1'b1);
    end
    // level request repeats while the pin stays low, then vanishes
    @(posedge core_clk);
    extPin <= 1'b0;
    io(ADDR_STATUS, 8'h80, 1'b1);
    vec(VEC_EXT);
    doRet();
    vec(VEC_EXT);
    @(posedge core_clk);
    extPin <= 1'b1;
    doRet();
    noVec(20);
    // expiry with the watchdog off is ignored
    @(posedge core_clk);
    wdtExpire <= 1'b1;
    @(posedge core_clk);
    wdtExpire <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("coreRst", 9'(coreRst), 9'h000);
    @(posedge core_clk);
    wdtEnable <= 1'b1;
    wdtExpire <= 1'b1;
    @(posedge core_clk);
    wdtExpire <= 1'b0;
    rstSeq(TOUT);
    rd(ADDR_GEN_MASK, REG_INIT);
    // pin held low well past the delay keeps the core halted
    @(posedge core_clk);
    rstPinN <= 1'b0;
    repeat (30) @(posedge core_clk);
    #1;
    chk("coreRst", 9'(coreRst), 9'h001);
    @(posedge core_clk);
    rstPinN <= 1'b1;
    rstSeq(TOUT);
    @(posedge core_clk);
    supplyOkN <= 1'b1;
    repeat (6) @(posedge core_clk);
    supplyOkN <= 1'b0;
    rstSeq(POR);
    giveVerdict();
  end
endmodule
